// ---- rtl/vec_gate_pkg.sv ----
package vec_gate_pkg;
    // register bus
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam logic [7:0] OFS_CTRL_ZERO = 8'h00;
    localparam logic [7:0] OFS_CTRL_FOUR = 8'h04;
    localparam logic [7:0] OFS_FP_MASK = 8'h08;
    localparam logic [7:0] OFS_XSTATE = 8'h0c;
    localparam logic [7:0] OFS_ID_ECX = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    // field positions
    localparam int CTRL_ZERO_EMU_BIT = 2;
    localparam int CTRL_FOUR_HANDLER_BIT = 10;
    localparam int CTRL_FOUR_OS_SAVE_BIT = 18;
    localparam int ID_CLMUL_BIT = 1;
    localparam int ID_CIPHER_BIT = 25;
    localparam int ID_SAVE_HW_BIT = 26;
    localparam int ID_OS_SAVE_BIT = 27;
    localparam int ID_WIDE_BIT = 28;
    localparam int XS_BASE_BIT = 0;
    localparam int XS_NARROW_BIT = 1;
    localparam int XS_WIDE_BIT = 2;
    localparam int EV_UNDEF_BIT = 0;
    localparam int EV_SIMD_BIT = 1;
    localparam int EV_GP_BIT = 2;
    localparam int EV_XS_BIT = 3;
    localparam int FP_EXC_W = 6;
    localparam int XS_W = 3;
    localparam int EV_W = 4;
    // reset values
    localparam logic [31:0] CR_RESET = 32'h0;
    localparam logic [5:0] FP_MASK_RESET = 6'h3f;
    localparam logic [2:0] XS_RESET = 3'h1;
    localparam logic [2:0] XS_BOTH = 3'h6;
    localparam logic [31:0] XS_INDEX_ZERO = 32'h0;
    // instruction classes seen at decode
    typedef enum logic [2:0] {
        CLS_OTHER = 3'h0,
        CLS_LEGACY_FP = 3'h1,
        CLS_WIDE_FP = 3'h2,
        CLS_WIDE_CIPHER = 3'h3,
        CLS_WIDE_CLMUL = 3'h4,
        CLS_XS_READ = 3'h5,
        CLS_XS_WRITE = 3'h6,
        CLS_SAVE_RESTORE = 3'h7
    } instr_class_t;
    typedef enum logic [1:0] {
        FLT_NONE = 2'h0,
        FLT_UNDEF = 2'h1,
        FLT_SIMD = 2'h2,
        FLT_GP = 2'h3
    } fault_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_EXEC = 2'h2
    } state_t;
endpackage

// ---- rtl/id_leaf.sv ----
`timescale 1ns/1ps
module id_leaf import vec_gate_pkg::*; #(
    parameter bit HAS_WIDE = 1'b1,
    parameter bit HAS_STATE_SAVE = 1'b1,
    parameter bit HAS_CIPHER = 1'b1,
    parameter bit HAS_CLMUL = 1'b1
) (
    // os state
    input wire logic os_save_in,
    // leaf 1 ecx
    output logic [31:0] ecx_out
);
    always_comb begin
        ecx_out = 32'h0;
        ecx_out[ID_CLMUL_BIT] = HAS_CLMUL;
        ecx_out[ID_CIPHER_BIT] = HAS_CIPHER;
        ecx_out[ID_SAVE_HW_BIT] = HAS_STATE_SAVE;
        ecx_out[ID_OS_SAVE_BIT] = os_save_in & HAS_STATE_SAVE;
        ecx_out[ID_WIDE_BIT] = HAS_WIDE;
    end
endmodule

// ---- rtl/fp_fault_eval.sv ----
`timescale 1ns/1ps
module fp_fault_eval import vec_gate_pkg::*; (
    // exception flags and masks
    input wire logic [FP_EXC_W-1:0] flags_in,
    input wire logic [FP_EXC_W-1:0] mask_in,
    input wire logic handler_in,
    // resolved fault
    output fault_t code_out
);
    // same treatment for narrow and wide forms
    always_comb begin
        code_out = FLT_NONE;
        if (|(flags_in & ~mask_in)) begin
            code_out = handler_in ? FLT_SIMD : FLT_UNDEF;
        end
    end
endmodule

// ---- rtl/vec_gate.sv ----
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module vec_gate import vec_gate_pkg::*; #(
    parameter bit HAS_WIDE = 1'b1,
    parameter bit HAS_STATE_SAVE = 1'b1,
    parameter bit HAS_CIPHER = 1'b1,
    parameter bit HAS_CLMUL = 1'b1
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // register port
    input wire logic [REG_AW-1:0] reg_addr_in,
    input wire logic [REG_DW-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [REG_DW-1:0] reg_rdata_out,
    // decode side
    input wire logic instr_valid_in,
    input wire instr_class_t instr_class_in,
    input wire logic instr_priv_in,
    input wire logic [31:0] instr_index_in,
    input wire logic [63:0] instr_data_in,
    output logic instr_ready_out,
    // execution side
    output logic exec_go_out,
    input wire logic fp_done_in,
    input wire logic [FP_EXC_W-1:0] fp_flags_in,
    // results
    output logic fault_valid_out,
    output fault_t fault_code_out,
    output logic result_valid_out,
    output logic [63:0] result_out,
    output logic [31:0] id_ecx_out,
    output logic irq_out
);
    typedef struct packed {
        state_t st;
        logic [31:0] ctrl_zero;
        logic [31:0] ctrl_four;
        logic [FP_EXC_W-1:0] fpmask;
        logic [XS_W-1:0] xs;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] irqmask;
        logic [REG_DW-1:0] rdata;
        logic go;
        logic fvalid;
        fault_t fcode;
        logic rvalid;
        logic [63:0] result;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        st: ST_IDLE,
        ctrl_zero: CR_RESET,
        ctrl_four: CR_RESET,
        fpmask: FP_MASK_RESET,
        xs: XS_RESET,
        status: 4'h0,
        irqmask: 4'h0,
        rdata: 32'h0,
        go: 1'b0,
        fvalid: 1'b0,
        fcode: FLT_NONE,
        rvalid: 1'b0,
        result: 64'h0
    };

    regs_t q;
    regs_t d;
    logic osx_en;
    logic wide_en;
    logic accept;
    fault_t fp_code;
    logic [EV_W-1:0] ev_set;

    function automatic logic wide_usable(input logic osx, input logic [XS_W-1:0] xs);
        wide_usable = HAS_WIDE && osx && (xs & XS_BOTH) == XS_BOTH;
    endfunction

    function automatic logic xs_value_ok(input logic [63:0] v);
        xs_value_ok = v[XS_BASE_BIT] && v[63:XS_W] == 61'h0
            && !(v[XS_WIDE_BIT] && !v[XS_NARROW_BIT]) && !(v[XS_WIDE_BIT] && !HAS_WIDE);
    endfunction

    assign osx_en = q.ctrl_four[CTRL_FOUR_OS_SAVE_BIT] & HAS_STATE_SAVE;
    assign wide_en = wide_usable(osx_en, q.xs);
    assign accept = instr_valid_in && instr_ready_out;
    assign instr_ready_out = q.st == ST_IDLE;

    id_leaf #(
        .HAS_WIDE(HAS_WIDE),
        .HAS_STATE_SAVE(HAS_STATE_SAVE),
        .HAS_CIPHER(HAS_CIPHER),
        .HAS_CLMUL(HAS_CLMUL)
    ) id_leaf_i (
        .os_save_in(osx_en),
        .ecx_out(id_ecx_out)
    );

    fp_fault_eval fp_fault_eval_i (
        .flags_in(fp_flags_in),
        .mask_in(q.fpmask),
        .handler_in(q.ctrl_four[CTRL_FOUR_HANDLER_BIT]),
        .code_out(fp_code)
    );

    always_comb begin
        d = q;
        d.go = 1'b0;
        d.fvalid = 1'b0;
        d.fcode = FLT_NONE;
        d.rvalid = 1'b0;
        d.result = q.result;
        d.rdata = 32'h0;
        ev_set = 4'h0;
        case (q.st)
            ST_IDLE: begin
                if (accept) begin
                    d.go = 1'b1;
                    case (instr_class_in)
                        CLS_WIDE_FP: begin
                            if (!wide_en) begin
                                d.go = 1'b0;
                                d.fcode = FLT_UNDEF;
                            end else begin
                                d.st = ST_EXEC;
                            end
                        end
                        CLS_LEGACY_FP: begin
                            if (q.ctrl_zero[CTRL_ZERO_EMU_BIT]) begin
                                d.go = 1'b0;
                                d.fcode = FLT_UNDEF;
                            end else begin
                                d.st = ST_EXEC;
                            end
                        end
                        CLS_WIDE_CIPHER: begin
                            if (!(wide_en && HAS_CIPHER)) begin
                                d.go = 1'b0;
                                d.fcode = FLT_UNDEF;
                            end
                        end
                        CLS_WIDE_CLMUL: begin
                            if (!(wide_en && HAS_CLMUL)) begin
                                d.go = 1'b0;
                                d.fcode = FLT_UNDEF;
                            end
                        end
                        CLS_SAVE_RESTORE: begin
                            if (!osx_en) begin
                                d.go = 1'b0;
                                d.fcode = FLT_UNDEF;
                            end
                        end
                        CLS_XS_READ: begin
                            d.go = 1'b0;
                            if (!osx_en) begin
                                d.fcode = FLT_UNDEF;
                            end else if (instr_index_in != XS_INDEX_ZERO) begin
                                d.fcode = FLT_GP;
                            end else begin
                                d.rvalid = 1'b1;
                                d.result = {61'h0, q.xs};
                            end
                        end
                        CLS_XS_WRITE: begin
                            d.go = 1'b0;
                            if (!osx_en) begin
                                d.fcode = FLT_UNDEF;
                            end else if (!instr_priv_in) begin
                                d.fcode = FLT_GP;
                            end else if (instr_index_in != XS_INDEX_ZERO || !xs_value_ok(instr_data_in)) begin
                                d.fcode = FLT_GP;
                            end else begin
                                d.xs = instr_data_in[XS_W-1:0];
                                ev_set[EV_XS_BIT] = 1'b1;
                            end
                        end
                        default: begin
                            d.go = 1'b1;
                        end
                    endcase
                end
            end
            ST_EXEC: begin
                if (fp_done_in) begin
                    d.st = ST_IDLE;
                    d.fcode = fp_code;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        d.fvalid = d.fcode != FLT_NONE;
        ev_set[EV_UNDEF_BIT] = d.fcode == FLT_UNDEF;
        ev_set[EV_SIMD_BIT] = d.fcode == FLT_SIMD;
        ev_set[EV_GP_BIT] = d.fcode == FLT_GP;
        // register port
        if (reg_wr_in) begin
            case (reg_addr_in)
                OFS_CTRL_ZERO: d.ctrl_zero = reg_wdata_in;
                OFS_CTRL_FOUR: begin
                    d.ctrl_four = reg_wdata_in;
                    d.ctrl_four[CTRL_FOUR_OS_SAVE_BIT] = reg_wdata_in[CTRL_FOUR_OS_SAVE_BIT] & HAS_STATE_SAVE;
                end
                OFS_FP_MASK: d.fpmask = reg_wdata_in[FP_EXC_W-1:0];
                OFS_STATUS: d.status = q.status & ~reg_wdata_in[EV_W-1:0];
                OFS_IRQ_MASK: d.irqmask = reg_wdata_in[EV_W-1:0];
                default: d.ctrl_zero = q.ctrl_zero;
            endcase
        end
        d.status = d.status | ev_set;
        if (reg_rd_in) begin
            case (reg_addr_in)
                OFS_CTRL_ZERO: d.rdata = q.ctrl_zero;
                OFS_CTRL_FOUR: d.rdata = q.ctrl_four;
                OFS_FP_MASK: d.rdata = {26'h0, q.fpmask};
                OFS_XSTATE: d.rdata = {29'h0, q.xs};
                OFS_ID_ECX: d.rdata = id_ecx_out;
                OFS_STATUS: d.rdata = {28'h0, q.status};
                OFS_IRQ_MASK: d.rdata = {28'h0, q.irqmask};
                default: d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q <= REGS_RESET;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign exec_go_out = q.go;
    assign fault_valid_out = q.fvalid;
    assign fault_code_out = q.fcode;
    assign result_valid_out = q.rvalid;
    assign result_out = q.result;
    assign irq_out = |(q.status & q.irqmask);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    property p_wide_off_undef;
        ce_in && accept && instr_class_in == CLS_WIDE_FP && !wide_en
            |=> fault_valid_out && fault_code_out == FLT_UNDEF && !exec_go_out && instr_ready_out;
    endproperty
    a_wide_off_undef: assert property (p_wide_off_undef) else $error("wide op not undefined");

    property p_emu_wide;
        ce_in && accept && instr_class_in == CLS_WIDE_FP && wide_en && q.ctrl_zero[CTRL_ZERO_EMU_BIT]
            |=> exec_go_out && !fault_valid_out && !instr_ready_out;
    endproperty
    a_emu_wide: assert property (p_emu_wide) else $error("emulation trapped wide op");

    property p_emu_legacy;
        ce_in && accept && instr_class_in == CLS_LEGACY_FP && q.ctrl_zero[CTRL_ZERO_EMU_BIT]
            |=> fault_code_out == FLT_UNDEF && !exec_go_out;
    endproperty
    a_emu_legacy: assert property (p_emu_legacy) else $error("legacy op not trapped");

    property p_fp_no_handler;
        ce_in && q.st == ST_EXEC && fp_done_in && |(fp_flags_in & ~q.fpmask)
            && !q.ctrl_four[CTRL_FOUR_HANDLER_BIT] |=> fault_valid_out && fault_code_out == FLT_UNDEF;
    endproperty
    a_fp_no_handler: assert property (p_fp_no_handler) else $error("fp fault not undefined");

    property p_fp_handler;
        ce_in && q.st == ST_EXEC && fp_done_in && |(fp_flags_in & ~q.fpmask)
            && q.ctrl_four[CTRL_FOUR_HANDLER_BIT] |=> fault_code_out == FLT_SIMD ##0 instr_ready_out;
    endproperty
    a_fp_handler: assert property (p_fp_handler) else $error("fp fault not simd");

    property p_fp_masked;
        ce_in && q.st == ST_EXEC && fp_done_in && (fp_flags_in & ~q.fpmask) == 6'h0
            |=> !fault_valid_out;
    endproperty
    a_fp_masked: assert property (p_fp_masked) else $error("masked fp fault raised");

    property p_write_unpriv;
        ce_in && accept && instr_class_in == CLS_XS_WRITE && osx_en && !instr_priv_in
            |=> fault_code_out == FLT_GP && q.xs == $past(q.xs);
    endproperty
    a_write_unpriv: assert property (p_write_unpriv) else $error("unprivileged write taken");

    property p_read_xs;
        ce_in && accept && instr_class_in == CLS_XS_READ && osx_en && instr_index_in == XS_INDEX_ZERO
            |=> result_valid_out && result_out[XS_W-1:0] == $past(q.xs) && !fault_valid_out;
    endproperty
    a_read_xs: assert property (p_read_xs) else $error("enable register read wrong");

    property p_id_osx;
        ce_in && reg_wr_in && reg_addr_in == OFS_CTRL_FOUR
            |=> id_ecx_out[ID_OS_SAVE_BIT] == ($past(reg_wdata_in[CTRL_FOUR_OS_SAVE_BIT]) && HAS_STATE_SAVE);
    endproperty
    a_id_osx: assert property (p_id_osx) else $error("os state flag wrong");

    property p_undef_irq;
        ce_in && q.irqmask[EV_UNDEF_BIT] && accept && instr_class_in == CLS_WIDE_FP && !wide_en
            && !(reg_wr_in && reg_addr_in == OFS_IRQ_MASK) |=> irq_out;
    endproperty
    a_undef_irq: assert property (p_undef_irq) else $error("undefined fault lost interrupt");

    property p_cipher_on;
        ce_in && accept && instr_class_in == CLS_WIDE_CIPHER && wide_en && HAS_CIPHER
            |=> exec_go_out && !fault_valid_out && instr_ready_out;
    endproperty
    a_cipher_on: assert property (p_cipher_on) else $error("enabled cipher op refused");

    property p_clmul_off;
        ce_in && accept && instr_class_in == CLS_WIDE_CLMUL && !wide_en
            |=> fault_code_out == FLT_UNDEF && !exec_go_out;
    endproperty
    a_clmul_off: assert property (p_clmul_off) else $error("clmul op not undefined");

    property p_save_off;
        ce_in && accept && instr_class_in == CLS_SAVE_RESTORE && !osx_en
            |=> fault_code_out == FLT_UNDEF && !exec_go_out;
    endproperty
    a_save_off: assert property (p_save_off) else $error("save op not undefined");

    property p_ce_hold;
        !ce_in |=> $stable(q);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");

    c_wide_undef: cover property (ce_in && accept && instr_class_in == CLS_WIDE_FP && !wide_en);
    c_fp_simd: cover property (fault_valid_out && fault_code_out == FLT_SIMD);
    c_read_ok: cover property (result_valid_out);
    c_xs_write: cover property (ce_in && accept && instr_class_in == CLS_XS_WRITE && osx_en && instr_priv_in);
endmodule

// ---- verif/tb_vec_gate.sv ----
`timescale 1ns/1ps
module tb_vec_gate import vec_gate_pkg::*; ;
    localparam logic [31:0] ID_HW = (32'h1 << ID_CLMUL_BIT) | (32'h1 << ID_CIPHER_BIT) |
        (32'h1 << ID_SAVE_HW_BIT) | (32'h1 << ID_WIDE_BIT);
    localparam logic [31:0] ID_OS = 32'h1 << ID_OS_SAVE_BIT;
    localparam logic [31:0] OS_ON = 32'h1 << CTRL_FOUR_OS_SAVE_BIT;
    localparam logic [31:0] HND = 32'h1 << CTRL_FOUR_HANDLER_BIT;
    localparam logic [31:0] EMU = 32'h1 << CTRL_ZERO_EMU_BIT;
    logic clk_in;
    logic rstn_in;
    logic ce_in;
    logic [REG_AW-1:0] reg_addr_in;
    logic [REG_DW-1:0] reg_wdata_in;
    logic reg_wr_in;
    logic reg_rd_in;
    logic [REG_DW-1:0] reg_rdata_out;
    logic instr_valid_in;
    instr_class_t instr_class_in;
    logic instr_priv_in;
    logic [31:0] instr_index_in;
    logic [63:0] instr_data_in;
    logic instr_ready_out;
    logic exec_go_out;
    logic fp_done_in;
    logic [FP_EXC_W-1:0] fp_flags_in;
    logic fault_valid_out;
    fault_t fault_code_out;
    logic result_valid_out;
    logic [63:0] result_out;
    logic [31:0] id_ecx_out;
    logic irq_out;
    int n_mismatch = 0;
    int n_tests = 0;

    vec_gate vec_gate_i (
        .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .instr_valid_in(instr_valid_in), .instr_class_in(instr_class_in),
        .instr_priv_in(instr_priv_in), .instr_index_in(instr_index_in),
        .instr_data_in(instr_data_in), .instr_ready_out(instr_ready_out),
        .exec_go_out(exec_go_out), .fp_done_in(fp_done_in), .fp_flags_in(fp_flags_in),
        .fault_valid_out(fault_valid_out), .fault_code_out(fault_code_out),
        .result_valid_out(result_valid_out), .result_out(result_out),
        .id_ecx_out(id_ecx_out), .irq_out(irq_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flt(input fault_t got, input fault_t exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: fault code %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk_word({32'h0, reg_rdata_out}, {32'h0, exp});
    endtask

    // one decode request; expected answer in the following cycle
    task automatic issue(input instr_class_t c, input logic p, input logic [31:0] idx,
                         input logic [63:0] d, input logic go, input fault_t code, input logic res);
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        instr_class_in <= c;
        instr_priv_in <= p;
        instr_index_in <= idx;
        instr_data_in <= d;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk_word({61'h0, exec_go_out, result_valid_out, fault_valid_out},
                 {61'h0, go, res, code != FLT_NONE});
        chk_flt(fault_code_out, code);
        chk_word({63'h0, instr_ready_out}, {63'h0, !(go && (c == CLS_WIDE_FP || c == CLS_LEGACY_FP))});
    endtask

    // completion of the outstanding fp operation
    task automatic fin(input logic [FP_EXC_W-1:0] f, input fault_t code);
        @(posedge clk_in);
        fp_done_in <= 1'b1;
        fp_flags_in <= f;
        @(posedge clk_in);
        fp_done_in <= 1'b0;
        #1;
        chk_word({62'h0, fault_valid_out, instr_ready_out}, {62'h0, code != FLT_NONE, 1'b1});
        chk_flt(fault_code_out, code);
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        conclude();
    end

    initial begin
        rstn_in = 1'b0;
        ce_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wdata_in = 32'h0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        instr_valid_in = 1'b0;
        instr_class_in = CLS_OTHER;
        instr_priv_in = 1'b0;
        instr_index_in = 32'h0;
        instr_data_in = 64'h0;
        fp_done_in = 1'b0;
        fp_flags_in = 6'h00;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        // reset values and identification without os support
        rd(OFS_CTRL_ZERO, 32'h0);
        rd(OFS_CTRL_FOUR, 32'h0);
        rd(OFS_FP_MASK, 32'h3f);
        rd(OFS_XSTATE, 32'h1);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_IRQ_MASK, 32'h0);
        rd(8'h1c, 32'h0);
        rd(OFS_ID_ECX, ID_HW);
        chk_word({32'h0, id_ecx_out}, {32'h0, ID_HW});
        // os state-save off
        issue(CLS_XS_READ, 1'b1, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        issue(CLS_SAVE_RESTORE, 1'b1, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        issue(CLS_WIDE_FP, 1'b1, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        issue(CLS_OTHER, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        chk_word({63'h0, irq_out}, 64'h0);
        // os turns state-save on
        wr(OFS_CTRL_FOUR, OS_ON);
        chk_word({32'h0, id_ecx_out}, {32'h0, ID_HW | ID_OS});
        issue(CLS_WIDE_CIPHER, 1'b1, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        issue(CLS_XS_READ, 1'b0, 32'h0, 64'h0, 1'b0, FLT_NONE, 1'b1);
        chk_word(result_out, 64'h1);
        issue(CLS_XS_READ, 1'b0, 32'h1, 64'h0, 1'b0, FLT_GP, 1'b0);
        issue(CLS_XS_WRITE, 1'b0, 32'h0, 64'h7, 1'b0, FLT_GP, 1'b0);
        rd(OFS_XSTATE, 32'h1);
        issue(CLS_XS_WRITE, 1'b1, 32'h0, 64'h7, 1'b0, FLT_NONE, 1'b0);
        rd(OFS_XSTATE, 32'h7);
        issue(CLS_XS_READ, 1'b0, 32'h0, 64'h0, 1'b0, FLT_NONE, 1'b1);
        chk_word(result_out, 64'h7);
        // wide fp with enables on, masks and handler flag
        issue(CLS_WIDE_FP, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        fin(6'h01, FLT_NONE);
        wr(OFS_FP_MASK, 32'h3e);
        issue(CLS_WIDE_FP, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        fin(6'h01, FLT_UNDEF);
        issue(CLS_WIDE_FP, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        fin(6'h02, FLT_NONE);
        wr(OFS_CTRL_FOUR, OS_ON | HND);
        rd(OFS_CTRL_FOUR, OS_ON | HND);
        issue(CLS_WIDE_FP, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        fin(6'h01, FLT_SIMD);
        issue(CLS_LEGACY_FP, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        fin(6'h01, FLT_SIMD);
        issue(CLS_WIDE_CIPHER, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        issue(CLS_WIDE_CLMUL, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        // emulation flag traps only legacy ops
        wr(OFS_CTRL_ZERO, EMU);
        issue(CLS_LEGACY_FP, 1'b0, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        issue(CLS_WIDE_FP, 1'b0, 32'h0, 64'h0, 1'b1, FLT_NONE, 1'b0);
        fin(6'h00, FLT_NONE);
        // os clears wide and narrow enables
        issue(CLS_XS_WRITE, 1'b1, 32'h0, 64'h5, 1'b0, FLT_GP, 1'b0);
        issue(CLS_XS_WRITE, 1'b1, 32'h0, 64'h1, 1'b0, FLT_NONE, 1'b0);
        issue(CLS_WIDE_FP, 1'b0, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        issue(CLS_WIDE_CIPHER, 1'b0, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        issue(CLS_WIDE_CLMUL, 1'b0, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        // status, mask and interrupt
        rd(OFS_STATUS, 32'hf);
        wr(OFS_IRQ_MASK, 32'h2);
        chk_word({63'h0, irq_out}, 64'h1);
        wr(OFS_STATUS, 32'h2);
        chk_word({63'h0, irq_out}, 64'h0);
        rd(OFS_STATUS, 32'hd);
        // undefined fault raises the interrupt when unmasked
        wr(OFS_STATUS, 32'hf);
        wr(OFS_IRQ_MASK, 32'h1);
        chk_word({63'h0, irq_out}, 64'h0);
        issue(CLS_WIDE_FP, 1'b0, 32'h0, 64'h0, 1'b0, FLT_UNDEF, 1'b0);
        chk_word({63'h0, irq_out}, 64'h1);
        // clock enable low freezes state
        @(posedge clk_in);
        ce_in <= 1'b0;
        wr(OFS_IRQ_MASK, 32'h3);
        @(posedge clk_in);
        ce_in <= 1'b1;
        rd(OFS_IRQ_MASK, 32'h1);
        conclude();
    end
endmodule
